/* sim/icem_chk.sv */
`timescale 1ns/1ps
module icem_chk (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] tx_ctx_irq_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic tx_context_summary_irq_o,
  input wire logic global_irq_enable_o,
  input wire logic [7:0] tx_context_event_bits_o,
  input wire logic [7:0] tx_context_enable_bits_o,
  input wire logic irq_o
);
  logic [7:0] irq_q;
  wire logic [7:0] ev = tx_context_event_bits_o;
  wire logic [7:0] en = tx_context_enable_bits_o;
  wire logic [7:0] ev_en = ev & en;
  wire logic [7:0] rise = tx_ctx_irq_i & ~irq_q;
  wire logic [7:0] wd = reg_wdata_i[7:0];
  wire logic [7:0] ev_set = (reg_wr_i && reg_addr_i == 8'h90) ? wd : 8'h00;
  wire logic [7:0] ev_clr = (reg_wr_i && reg_addr_i == 8'h84) ? wd : 8'h00;
  wire logic [7:0] en_set = (reg_wr_i && reg_addr_i == 8'h98) ? wd : 8'h00;
  wire logic [7:0] en_clr = (reg_wr_i && reg_addr_i == 8'h9c) ? wd : 8'h00;
  wire logic [7:0] cause = rise | ev_set;

  // Line history, cleared like the design's edge detector
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_q <= 8'h00;
    end else begin
      irq_q <= tx_ctx_irq_i;
    end
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_tx_sum_or: assert property (
    tx_context_summary_irq_o == |$past(ev_en))
    else $error("tx summary differs from event and mask");
  a_tx_latch: assert property (1'b1 |=>
    (ev & $past(rise)) == $past(rise))
    else $error("tx line edge did not latch");
  a_tx_sticky: assert property (
    (~ev & $past(ev) & ~$past(ev_clr)) == 8'h00)
    else $error("tx event lost without clear");
  a_tx_noset: assert property (
    (ev & ~$past(ev) & ~$past(cause)) == 8'h00)
    else $error("tx event set without cause");
  a_mask_upd: assert property (
    en == (($past(en) | $past(en_set)) & ~$past(en_clr)))
    else $error("tx mask update wrong");
  a_rd_masked: assert property (
    reg_rd_i && reg_addr_i == 8'h84 |=>
    reg_rdata_o == {24'h000000, $past(ev_en)})
    else $error("clear address read wrong");
  a_rd_mask: assert property (
    reg_rd_i && reg_addr_i inside {8'h98, 8'h9c} |=>
    reg_rdata_o == {24'h000000, $past(en)})
    else $error("mask read wrong");
  a_rd_idle: assert property (
    !$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside read slot");
  a_irq_gate: assert property (!global_irq_enable_o |-> !irq_o)
    else $error("irq without global enable");

  cover property ($rose(tx_context_summary_irq_o));
  cover property ($rose(irq_o));
  cover property (reg_rd_i && reg_addr_i == 8'h84);
endmodule : icem_chk

bind icem_top icem_chk i_icem_chk (.core_clk_i(core_clk_i),
  .rst_n_i(rst_n_i), .tx_ctx_irq_i(tx_ctx_irq_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .irq_o(irq_o),
  .tx_context_summary_irq_o(tx_context_summary_irq_o),
  .global_irq_enable_o(global_irq_enable_o),
  .tx_context_event_bits_o(tx_context_event_bits_o),
  .tx_context_enable_bits_o(tx_context_enable_bits_o));

/* sim/test_iso_context_irq_event_mask.sv */
`timescale 1ns/1ps
module test_iso_context_irq_event_mask;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] tx_irq = 8'h00;
  logic [3:0] rx_irq = 4'h0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic tx_sum, rx_sum, gen, irq;
  logic [7:0] ev, en;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [7:0] idle_map [12] = '{8'h84, 8'h90, 8'h98, 8'h9c, 8'ha0, 8'ha4,
    8'ha8, 8'hac, 8'hb0, 8'hb4, 8'hb8, 8'h00};

  // Free-running core clock
  always #2.5 core_clk_i = ~core_clk_i;

  icem_top i_icem_top (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .tx_ctx_irq_i(tx_irq), .rx_ctx_irq_i(rx_irq), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .tx_context_summary_irq_o(tx_sum), .rx_context_summary_irq_o(rx_sum),
    .global_irq_enable_o(gen), .tx_context_event_bits_o(ev),
    .tx_context_enable_bits_o(en), .irq_o(irq));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Lands just after an edge so registered outputs have settled
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : tick

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk_i);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk_i);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask : rd_chk

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  // Hang guard, far above the roughly 120 cycles the run needs
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      give_verdict();
    end
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    tick(1);
    check({tx_sum, rx_sum, gen, irq, ev, en}, 20'h0);
    foreach (idle_map[i]) rd_chk(idle_map[i], 32'h0);
    wr_reg(8'h98, 32'hffff_ffff);
    rd_chk(8'h9c, 32'hff);
    wr_reg(8'h9c, 32'h0000_000f);
    wr_reg(8'h98, 32'h0);
    rd_chk(8'h98, 32'hf0);
    rd_chk(8'h9c, 32'hf0);
    // All lines rise; masked contexts must still latch
    @(posedge core_clk_i);
    tx_irq <= 8'hff;
    tick(2);
    check(ev, 8'hff);
    check(tx_sum, 1'b1);
    rd_chk(8'h90, 32'hff);
    wr_reg(8'h84, 32'hff);
    tick(2);
    check(ev, 8'h00);
    @(posedge core_clk_i);
    tx_irq <= 8'h00;
    @(posedge core_clk_i);
    tx_irq <= 8'h08;
    tick(2);
    check(ev, 8'h08);
    check(tx_sum, 1'b0);
    rd_chk(8'h84, 32'h0);
    wr_reg(8'h90, 32'hffff_ff10);
    rd_chk(8'h90, 32'h18);
    rd_chk(8'h84, 32'h10);
    check(tx_sum, 1'b1);
    wr_reg(8'h84, 32'h0);
    tick(1);
    check(ev, 8'h18);
    // Clearing a mask bit drops the summary but keeps the event
    wr_reg(8'h9c, 32'h10);
    tick(1);
    check(tx_sum, 1'b0);
    check(ev, 8'h18);
    // A line edge in the clear cycle wins over the clear
    @(posedge core_clk_i);
    addr <= 8'h84;
    wdata <= 32'hff;
    wr <= 1'b1;
    tx_irq <= 8'h09;
    @(posedge core_clk_i);
    wr <= 1'b0;
    tick(1);
    check(ev, 8'h01);
    // Interrupt output held off until the global enable is on
    wr_reg(8'hbc, 32'h1);
    tick(2);
    check(irq, 1'b0);
    rd_chk(8'hb4, 32'h1);
    rd_chk(8'hbc, 32'h1);
    wr_reg(8'hb0, 32'h8000_0000);
    tick(0);
    check({gen, irq}, 2'b11);
    rd_chk(8'hb0, 32'h8000_0000);
    wr_reg(8'hb0, 32'h0);
    tick(0);
    check({gen, irq}, 2'b00);
    wr_reg(8'hb0, 32'h8000_0000);
    tick(0);
    check(irq, 1'b1);
    wr_reg(8'hb8, 32'h1);
    tick(2);
    check({gen, irq}, 2'b10);
    // Receive side
    @(posedge core_clk_i);
    rx_irq <= 4'h4;
    wr_reg(8'ha8, 32'h4);
    tick(2);
    check(rx_sum, 1'b1);
    rd_chk(8'ha0, 32'h4);
    rd_chk(8'ha4, 32'h4);
    rd_chk(8'hac, 32'h4);
    rd_chk(8'hb4, 32'h2);
    wr_reg(8'hac, 32'hf);
    wr_reg(8'ha0, 32'hffff_fff1);
    rd_chk(8'ha0, 32'h5);
    rd_chk(8'ha4, 32'h0);
    check(rx_sum, 1'b0);
    // Reset in mid-run clears all state
    @(posedge core_clk_i);
    tx_irq <= 8'h00;
    rx_irq <= 4'h0;
    rst_n_i <= 1'b0;
    tick(2);
    check({tx_sum, rx_sum, gen, irq, ev, en}, 20'h0);
    @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    rd_chk(8'h90, 32'h0);
    give_verdict();
  end
endmodule : test_iso_context_irq_event_mask

/* verilog/icem_event_latch.sv */
`timescale 1ns/1ps
module icem_event_latch #(
  parameter int W = 8
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] irq_i,
  input wire logic [W-1:0] sw_set_i,
  input wire logic [W-1:0] sw_clr_i,
  output logic [W-1:0] event_o
);

  logic [W-1:0] irq_prev;
  logic [W-1:0] next_irq_prev;
  logic [W-1:0] next_event;

  // Per-context sticky bit; set terms win so no edge is lost on a clear
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_comb begin
      next_event[i] = event_o[i];
      if (sw_clr_i[i]) begin
        next_event[i] = 1'b0;
      end
      if ((irq_i[i] && !irq_prev[i]) || sw_set_i[i]) begin
        next_event[i] = 1'b1;
      end
    end
  end

  // Previous level for edge detection
  always_comb begin
    next_irq_prev = irq_i;
  end

  // Registers only
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_prev <= '0;
      event_o <= '0;
    end else begin
      irq_prev <= next_irq_prev;
      event_o <= next_event;
    end
  end

endmodule : icem_event_latch

/* verilog/icem_pkg.sv */
package icem_pkg;

  // Context counts and bus widths
  localparam int TX_CTX = 8;
  localparam int RX_CTX = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STAT_W = 2;

  // Register byte offsets
  localparam logic [7:0] OFS_TX_EVT_CLR = 8'h84;
  localparam logic [7:0] OFS_TX_EVT_SET = 8'h90;
  localparam logic [7:0] OFS_TX_EN_SET = 8'h98;
  localparam logic [7:0] OFS_TX_EN_CLR = 8'h9c;
  localparam logic [7:0] OFS_RX_EVT_SET = 8'ha0;
  localparam logic [7:0] OFS_RX_EVT_CLR = 8'ha4;
  localparam logic [7:0] OFS_RX_EN_SET = 8'ha8;
  localparam logic [7:0] OFS_RX_EN_CLR = 8'hac;
  localparam logic [7:0] OFS_GLB_CTRL = 8'hb0;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'hb4;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'hb8;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'hbc;

  // Field positions
  localparam int GLB_EN_BIT = 31;
  localparam int STAT_TX_BIT = 0;
  localparam int STAT_RX_BIT = 1;

  // Values after reset
  localparam logic [TX_CTX-1:0] TX_EVT_RST = 8'h00;
  localparam logic [TX_CTX-1:0] TX_EN_RST = 8'h00;
  localparam logic [RX_CTX-1:0] RX_EVT_RST = 4'h0;
  localparam logic [RX_CTX-1:0] RX_EN_RST = 4'h0;
  localparam logic GLB_EN_RST = 1'b0;
  localparam logic [STAT_W-1:0] STAT_RST = 2'h0;
  localparam logic [STAT_W-1:0] IRQ_EN_RST = 2'h0;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  // Register selected by an address
  typedef enum {
    SEL_NONE,
    SEL_TX_EVT_CLR,
    SEL_TX_EVT_SET,
    SEL_TX_EN_SET,
    SEL_TX_EN_CLR,
    SEL_RX_EVT_SET,
    SEL_RX_EVT_CLR,
    SEL_RX_EN_SET,
    SEL_RX_EN_CLR,
    SEL_GLB_CTRL,
    SEL_IRQ_STATUS,
    SEL_IRQ_CLEAR,
    SEL_IRQ_ENABLE
  } icem_reg_sel_t;

endpackage : icem_pkg

/* verilog/icem_top.sv */
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
module icem_top (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Context completion interrupt lines from the DMA engines
  input wire logic [icem_pkg::TX_CTX-1:0] tx_ctx_irq_i,
  input wire logic [icem_pkg::RX_CTX-1:0] rx_ctx_irq_i,
  // Register port
  input wire logic [icem_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [icem_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [icem_pkg::DATA_W-1:0] reg_rdata_o,
  // Summaries and state
  output logic tx_context_summary_irq_o,
  output logic rx_context_summary_irq_o,
  output logic global_irq_enable_o,
  output logic [icem_pkg::TX_CTX-1:0] tx_context_event_bits_o,
  output logic [icem_pkg::TX_CTX-1:0] tx_context_enable_bits_o,
  output logic irq_o
);

  // Address decode shared by the write and read paths
  // Unmapped addresses decode to no register, so they do nothing
  function automatic icem_pkg::icem_reg_sel_t decode_addr(
    input logic [icem_pkg::ADDR_W-1:0] addr
  );
    icem_pkg::icem_reg_sel_t sel;
    sel = icem_pkg::SEL_NONE;
    case (addr)
      icem_pkg::OFS_TX_EVT_CLR: sel = icem_pkg::SEL_TX_EVT_CLR;
      icem_pkg::OFS_TX_EVT_SET: sel = icem_pkg::SEL_TX_EVT_SET;
      icem_pkg::OFS_TX_EN_SET: sel = icem_pkg::SEL_TX_EN_SET;
      icem_pkg::OFS_TX_EN_CLR: sel = icem_pkg::SEL_TX_EN_CLR;
      icem_pkg::OFS_RX_EVT_SET: sel = icem_pkg::SEL_RX_EVT_SET;
      icem_pkg::OFS_RX_EVT_CLR: sel = icem_pkg::SEL_RX_EVT_CLR;
      icem_pkg::OFS_RX_EN_SET: sel = icem_pkg::SEL_RX_EN_SET;
      icem_pkg::OFS_RX_EN_CLR: sel = icem_pkg::SEL_RX_EN_CLR;
      icem_pkg::OFS_GLB_CTRL: sel = icem_pkg::SEL_GLB_CTRL;
      icem_pkg::OFS_IRQ_STATUS: sel = icem_pkg::SEL_IRQ_STATUS;
      icem_pkg::OFS_IRQ_CLEAR: sel = icem_pkg::SEL_IRQ_CLEAR;
      icem_pkg::OFS_IRQ_ENABLE: sel = icem_pkg::SEL_IRQ_ENABLE;
      default: sel = icem_pkg::SEL_NONE;
    endcase
    return sel;
  endfunction : decode_addr

  // Register selected by the current strobe, or none
  icem_pkg::icem_reg_sel_t wr_sel;
  icem_pkg::icem_reg_sel_t rd_sel;

  // Write-side strobes, one per set or clear port
  // A strobe lasts one cycle, so each written one acts exactly once
  logic [icem_pkg::TX_CTX-1:0] tx_evt_set_w;
  logic [icem_pkg::TX_CTX-1:0] tx_evt_clr_w;
  logic [icem_pkg::RX_CTX-1:0] rx_evt_set_w;
  logic [icem_pkg::RX_CTX-1:0] rx_evt_clr_w;

  // Event bits held by the sticky latches
  // (transmit events leave through their own output port)
  logic [icem_pkg::RX_CTX-1:0] rx_evt;

  // Enable masks and block-level control
  logic [icem_pkg::TX_CTX-1:0] next_tx_en;
  logic [icem_pkg::RX_CTX-1:0] rx_en;
  logic [icem_pkg::RX_CTX-1:0] next_rx_en;
  logic next_glb_en;

  // Interrupt status, enable and output
  logic [icem_pkg::STAT_W-1:0] irq_status;
  logic [icem_pkg::STAT_W-1:0] next_irq_status;
  logic [icem_pkg::STAT_W-1:0] irq_en;
  logic [icem_pkg::STAT_W-1:0] next_irq_en;
  logic [icem_pkg::STAT_W-1:0] summary_rise;
  logic next_irq;

  // Summaries
  logic tx_sum_now;
  logic rx_sum_now;
  logic next_tx_sum;
  logic next_rx_sum;

  // Read data
  logic [icem_pkg::DATA_W-1:0] next_rdata;

  // Per-context contribution to each summary; the mask gates this path
  // and the clear-address readback, so masked events are still recorded and readable at the set address
  logic [icem_pkg::TX_CTX-1:0] tx_contrib;
  logic [icem_pkg::RX_CTX-1:0] rx_contrib;

  for (genvar c = 0; c < icem_pkg::TX_CTX; c++) begin : g_tx_contrib
    assign tx_contrib[c] = tx_context_event_bits_o[c] &
      tx_context_enable_bits_o[c];
  end

  for (genvar c = 0; c < icem_pkg::RX_CTX; c++) begin : g_rx_contrib
    assign rx_contrib[c] = rx_evt[c] & rx_en[c];
  end

  // Decode once per port direction
  // The master never raises both strobes, so one address serves both
  always_comb begin
    wr_sel = reg_wr_i ? decode_addr(reg_addr_i) : icem_pkg::SEL_NONE;
    rd_sel = reg_rd_i ? decode_addr(reg_addr_i) : icem_pkg::SEL_NONE;
  end

  // Event set and clear strobes; only ones written take effect
  always_comb begin
    tx_evt_set_w = '0;
    tx_evt_clr_w = '0;
    rx_evt_set_w = '0;
    rx_evt_clr_w = '0;
    if (wr_sel == icem_pkg::SEL_TX_EVT_SET) begin
      tx_evt_set_w = reg_wdata_i[icem_pkg::TX_CTX-1:0];
    end
    if (wr_sel == icem_pkg::SEL_TX_EVT_CLR) begin
      tx_evt_clr_w = reg_wdata_i[icem_pkg::TX_CTX-1:0];
    end
    if (wr_sel == icem_pkg::SEL_RX_EVT_SET) begin
      rx_evt_set_w = reg_wdata_i[icem_pkg::RX_CTX-1:0];
    end
    if (wr_sel == icem_pkg::SEL_RX_EVT_CLR) begin
      rx_evt_clr_w = reg_wdata_i[icem_pkg::RX_CTX-1:0];
    end
  end

  // Transmit events: input lines pulse on last-output completion
  // with irq bits; the latch records them whatever the mask says
  // The upstream engine raises a line only for commands with irq bits
  icem_event_latch #(
    .W(icem_pkg::TX_CTX)
  ) u_tx_events (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .irq_i(tx_ctx_irq_i),
    .sw_set_i(tx_evt_set_w),
    .sw_clr_i(tx_evt_clr_w),
    .event_o(tx_context_event_bits_o)
  );

  // Receive events: any input command completion with irq bits
  // A line held high records one event; only its rising edge counts
  icem_event_latch #(
    .W(icem_pkg::RX_CTX)
  ) u_rx_events (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .irq_i(rx_ctx_irq_i),
    .sw_set_i(rx_evt_set_w),
    .sw_clr_i(rx_evt_clr_w),
    .event_o(rx_evt)
  );

  // Mask registers; set and clear live at different addresses so
  // the two can never meet in one cycle
  // Zero bits of the written word leave mask bits as they were
  always_comb begin
    next_tx_en = tx_context_enable_bits_o;
    next_rx_en = rx_en;
    case (wr_sel)
      icem_pkg::SEL_TX_EN_SET: begin
        next_tx_en = tx_context_enable_bits_o |
          reg_wdata_i[icem_pkg::TX_CTX-1:0];
      end
      icem_pkg::SEL_TX_EN_CLR: begin
        next_tx_en = tx_context_enable_bits_o &
          ~reg_wdata_i[icem_pkg::TX_CTX-1:0];
      end
      icem_pkg::SEL_RX_EN_SET: begin
        next_rx_en = rx_en | reg_wdata_i[icem_pkg::RX_CTX-1:0];
      end
      icem_pkg::SEL_RX_EN_CLR: begin
        next_rx_en = rx_en & ~reg_wdata_i[icem_pkg::RX_CTX-1:0];
      end
      default: begin
        next_tx_en = tx_context_enable_bits_o;
        next_rx_en = rx_en;
      end
    endcase
  end

  // Masks have no defined power-up value in hardware; they clear
  // here so that no context reaches a summary before software asks
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_context_enable_bits_o <= icem_pkg::TX_EN_RST;
      rx_en <= icem_pkg::RX_EN_RST;
    end else begin
      tx_context_enable_bits_o <= next_tx_en;
      rx_en <= next_rx_en;
    end
  end

  // Global enable; plain read/write bit
  // Only the enable bit is stored; other bits of the word are dropped
  always_comb begin
    next_glb_en = global_irq_enable_o;
    if (wr_sel == icem_pkg::SEL_GLB_CTRL) begin
      next_glb_en = reg_wdata_i[icem_pkg::GLB_EN_BIT];
    end
  end

  // Global enable register
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      global_irq_enable_o <= icem_pkg::GLB_EN_RST;
    end else begin
      global_irq_enable_o <= next_glb_en;
    end
  end

  // Summaries are unlatched OR of event and mask; flopped once so
  // the output comes from a register, costing one cycle of lag;
  // software polling the summary must allow for that cycle
  always_comb begin
    tx_sum_now = |tx_contrib;
    rx_sum_now = |rx_contrib;
    next_tx_sum = tx_sum_now;
    next_rx_sum = rx_sum_now;
  end

  // Summary registers
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_context_summary_irq_o <= 1'b0;
      rx_context_summary_irq_o <= 1'b0;
    end else begin
      tx_context_summary_irq_o <= next_tx_sum;
      rx_context_summary_irq_o <= next_rx_sum;
    end
  end

  // Status records each summary rising; a rise in the clear cycle
  // survives because the set term is applied last
  always_comb begin
    // A rise is a summary about to go from low to high
    summary_rise = '0;
    summary_rise[icem_pkg::STAT_TX_BIT] = tx_sum_now &
      ~tx_context_summary_irq_o;
    summary_rise[icem_pkg::STAT_RX_BIT] = rx_sum_now &
      ~rx_context_summary_irq_o;
    next_irq_status = irq_status;
    if (wr_sel == icem_pkg::SEL_IRQ_CLEAR) begin
      next_irq_status = irq_status &
        ~reg_wdata_i[icem_pkg::STAT_W-1:0];
    end
    next_irq_status = next_irq_status | summary_rise;
    // Enable is a plain read/write register
    next_irq_en = irq_en;
    if (wr_sel == icem_pkg::SEL_IRQ_ENABLE) begin
      next_irq_en = reg_wdata_i[icem_pkg::STAT_W-1:0];
    end
    // Level output, held off entirely by the global enable; the next
    // value is taken so the pin drops on the very edge the enable does
    next_irq = next_glb_en &
      (|(next_irq_status & next_irq_en));
  end

  // Status, interrupt enable and interrupt pin
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_status <= icem_pkg::STAT_RST;
      irq_en <= icem_pkg::IRQ_EN_RST;
      irq_o <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq_en <= next_irq_en;
      irq_o <= next_irq;
    end
  end

  // Read mux; data stands only in the cycle after the strobe,
  // unmapped and write-only addresses read zero,
  // and no read ever changes any state
  always_comb begin
    next_rdata = '0;
    case (rd_sel)
      icem_pkg::SEL_TX_EVT_SET: begin
        next_rdata = 32'(tx_context_event_bits_o);
      end
      icem_pkg::SEL_TX_EVT_CLR: begin
        next_rdata = 32'(tx_context_event_bits_o &
          tx_context_enable_bits_o);
      end
      // Masks read back the same at their set and clear addresses
      icem_pkg::SEL_TX_EN_SET,
      icem_pkg::SEL_TX_EN_CLR: begin
        next_rdata = 32'(tx_context_enable_bits_o);
      end
      icem_pkg::SEL_RX_EVT_SET: begin
        next_rdata = 32'(rx_evt);
      end
      icem_pkg::SEL_RX_EVT_CLR: begin
        next_rdata = 32'(rx_evt & rx_en);
      end
      icem_pkg::SEL_RX_EN_SET,
      icem_pkg::SEL_RX_EN_CLR: begin
        next_rdata = 32'(rx_en);
      end
      icem_pkg::SEL_GLB_CTRL: begin
        next_rdata[icem_pkg::GLB_EN_BIT] = global_irq_enable_o;
      end
      icem_pkg::SEL_IRQ_STATUS: begin
        next_rdata = 32'(irq_status);
      end
      icem_pkg::SEL_IRQ_ENABLE: begin
        next_rdata = 32'(irq_en);
      end
      default: begin
        next_rdata = '0;
      end
    endcase
  end

  // Read data register; it falls back to zero after one cycle so a
  // stale word is never taken for a fresh answer
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= icem_pkg::RDATA_RST;
    end else begin
      reg_rdata_o <= next_rdata;
    end
  end

endmodule : icem_top
